// file: rtl/iod_decoder.sv
// iod_decoder: lower I/O register space (0x00-0x3f) of an 8-bit core.
// assumes: core on ref_clk drives one request a cycle; events come from
// same-clock peripherals; port pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
`include "iod_map.svh"

// Behaviour
// - bit set and clear act only on addresses 0x00 to 0x1F
// - core can test one bit there and skip on set or clear
// - status flags clear on writing one; writing zero leaves them
// - bit set or clear changes only the addressed bit, no other flags
// - short I/O instructions use addresses 0x00 to 0x3F
// - data-space accesses see each register at I/O address plus 0x20
// - range 0x60 to 0xFF reachable only by data-space accesses
module iod_decoder
	import iod_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             clk_en,
	input  wire iod_req_t         req,
	output var iod_rsp_t          rsp,
	input  wire iod_evt_t         evt,
	input  wire iod_stat_t        stat,
	input  wire logic [3:0][7:0]  pins_in,
	output logic [63:0][7:0]      io_regs,
	output logic [3:0][7:0]       pin_level
);

	iod_state_t  st_r;
	iod_state_t  st_nxt;
	logic [5:0]  iaddr;
	logic        sel;
	logic        do_rd;
	logic        do_wr;
	logic        bit_ok;
	logic [7:0]  wm;
	logic [7:0]  wd;
	logic [7:0]  rw;
	logic [7:0]  fl;
	logic [7:0]  cur;
	logic [7:0]  bsel;

	// bits that software may store
	function automatic logic [7:0] rw_mask(input logic [5:0] a);
		logic [7:0] m;
		m = 8'h00;
		case (a)
			`IOD_PORT_B_OUTPUT_DIR, `IOD_PORT_B_OUTPUT_OUT, `IOD_PORT_C_OUTPUT_DIR, `IOD_PORT_C_OUTPUT_OUT,
			`IOD_PORT_D_OUTPUT_DIR, `IOD_PORT_D_OUTPUT_OUT, `IOD_PULL_CTL, `IOD_SCRATCH0,
			`IOD_NVM_DATA, `IOD_NVM_ADDR_LO, `IOD_TMR0_COUNT, `IOD_TMR0_CMP_A,
			`IOD_TMR0_CMP_B, `IOD_SCRATCH1, `IOD_SCRATCH2, `IOD_SER_CTL,
			`IOD_SER_DATA, `IOD_DBG_DATA:
				m = `IOD_M_FULL;
			`IOD_PORT_A_OUTPUT_DIR, `IOD_PORT_A_OUTPUT_OUT:
				m = `IOD_M_PORT_A_OUTPUT;
			`IOD_EXTLN_MASK:
				m = `IOD_M_EXTLN;
			`IOD_NVM_CTL:
				m = `IOD_M_NVM_CTL;
			`IOD_PRESC_CTL:
				m = `IOD_M_PRESC;
			`IOD_TMR0_CTL:
				m = `IOD_M_TMR0_CTL;
			`IOD_SER_STAT:
				m = `IOD_M_SER_STAT;
			`IOD_CMP_CS:
				m = `IOD_M_CMP_RW;
			`IOD_SLEEP_CTL:
				m = `IOD_M_SLEEP;
			default:
				m = 8'h00;
		endcase
		return m;
	endfunction : rw_mask

	// flags that hardware sets and a written one clears
	function automatic logic [7:0] w1c_mask(input logic [5:0] a);
		logic [7:0] m;
		m = 8'h00;
		case (a)
			`IOD_TMR0_FLAGS:
				m = `IOD_F_TMR0;
			`IOD_TMR1_FLAGS:
				m = `IOD_F_TMR1;
			`IOD_PCGRP_FLAGS:
				m = `IOD_F_PCGRP;
			`IOD_EXTLN_FLAGS:
				m = `IOD_F_EXTLN;
			`IOD_CMP_CS:
				m = `IOD_F_CMP;
			default:
				m = 8'h00;
		endcase
		return m;
	endfunction : w1c_mask

	// visible value of one io address
	function automatic logic [7:0] rd_val(
		input iod_state_t s,
		input iod_stat_t  t,
		input logic [5:0] a
	);
		logic [7:0] v;
		v = s.io[a] & (rw_mask(a) | w1c_mask(a));
		if (a == `IOD_PORT_B_OUTPUT_LVL)
		begin
			v = s.lvl[1];
		end
		else if (a == `IOD_PORT_C_OUTPUT_LVL)
		begin
			v = s.lvl[2];
		end
		else if (a == `IOD_PORT_D_OUTPUT_LVL)
		begin
			v = s.lvl[3];
		end
		else if (a == `IOD_PORT_A_OUTPUT_LVL)
		begin
			v = s.lvl[0] & `IOD_M_PORT_A_OUTPUT;
		end
		else if (a == `IOD_SER_STAT)
		begin
			v[`IOD_SER_FLAG_LSB +: 2] = t.ser_flags;
		end
		else if (a == `IOD_CMP_CS)
		begin
			v[`IOD_CMP_LVL_BIT] = t.cmp_level;
		end
		return v;
	endfunction : rd_val

	always_comb
	begin
		st_nxt = st_r;
		iaddr  = 6'h00;
		sel    = 1'b0;
		do_rd  = 1'b0;
		do_wr  = 1'b0;
		bit_ok = 1'b0;
		wm     = 8'h00;
		wd     = 8'h00;
		rsp    = '0;
		bsel   = 8'h01 << req.bit_sel;

		// pins: a change counts once the second and third stage agree
		st_nxt.s1 = pins_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		for (int p = 0; p < 4; p++)
		begin
			st_nxt.lvl[p] = (st_r.lvl[p] & (st_r.s2[p] ^ st_r.s3[p]))
				| (st_r.s3[p] & ~(st_r.s2[p] ^ st_r.s3[p]));
		end

		if (req.valid)
		begin
			case (req.op)
				iod_op_io_in, iod_op_io_out:
				begin
					// short instructions carry only a 6-bit io address
					sel   = (req.addr[7:6] == 2'b00);
					iaddr = req.addr[5:0];
					do_rd = sel && (req.op == iod_op_io_in);
					do_wr = sel && (req.op == iod_op_io_out);
					wm    = `IOD_M_FULL;
					wd    = req.wdata;
				end
				iod_op_data_space_load, iod_op_data_space_store:
				begin
					if (req.addr >= `IOD_EXT_BASE)
					begin
						rsp.ext_sel = 1'b1;
					end
					else if (req.addr >= `IOD_DS_OFFSET)
					begin
						sel   = 1'b1;
						iaddr = 6'(req.addr - `IOD_DS_OFFSET);
					end
					do_rd = sel && (req.op == iod_op_data_space_load);
					do_wr = sel && (req.op == iod_op_data_space_store);
					wm    = `IOD_M_FULL;
					wd    = req.wdata;
				end
				iod_op_set_io_bit_instruction, iod_op_clr_io_bit_instruction:
				begin
					bit_ok = (req.addr[7:6] == 2'b00) && (req.addr[5:0] <= `IOD_BIT_TOP);
					sel    = bit_ok;
					iaddr  = req.addr[5:0];
					do_wr  = bit_ok;
					// only the addressed bit is in the write mask
					wm     = bsel;
					wd     = (req.op == iod_op_set_io_bit_instruction) ? 8'hff : 8'h00;
				end
				iod_op_skip_if_io_bit_set, iod_op_skip_if_io_bit_clear:
				begin
					bit_ok = (req.addr[7:6] == 2'b00) && (req.addr[5:0] <= `IOD_BIT_TOP);
					sel    = bit_ok;
					iaddr  = req.addr[5:0];
					do_rd  = bit_ok;
				end
				default:
				begin
					sel = 1'b0;
				end
			endcase
		end

		rw  = rw_mask(iaddr);
		fl  = w1c_mask(iaddr);
		cur = rd_val(st_r, stat, iaddr);

		// read side answers in the same cycle
		rsp.hit     = sel;
		rsp.io_addr = iaddr;
		rsp.rd_stb  = do_rd;
		rsp.wr_stb  = do_wr;
		rsp.rdata   = do_rd ? cur : 8'h00;
		if (bit_ok && (req.op == iod_op_skip_if_io_bit_set))
		begin
			rsp.skip = |(cur & bsel);
		end
		else if (bit_ok && (req.op == iod_op_skip_if_io_bit_clear))
		begin
			rsp.skip = ~|(cur & bsel);
		end

		if (do_wr)
		begin
			// reserved bits are outside rw and fl, so they never store
			st_nxt.io[iaddr] = (st_r.io[iaddr] & ~(rw & wm)) | (wd & rw & wm);
			st_nxt.io[iaddr] = st_nxt.io[iaddr] & ~(wd & fl & wm);
		end

		// set wins over a clear in the same cycle
		st_nxt.io[`IOD_TMR0_FLAGS]  = st_nxt.io[`IOD_TMR0_FLAGS]  | (evt.tmr0  & `IOD_F_TMR0);
		st_nxt.io[`IOD_TMR1_FLAGS]  = st_nxt.io[`IOD_TMR1_FLAGS]  | (evt.tmr1  & `IOD_F_TMR1);
		st_nxt.io[`IOD_PCGRP_FLAGS] = st_nxt.io[`IOD_PCGRP_FLAGS] | (evt.pcgrp & `IOD_F_PCGRP);
		st_nxt.io[`IOD_EXTLN_FLAGS] = st_nxt.io[`IOD_EXTLN_FLAGS] | (evt.extln & `IOD_F_EXTLN);
		st_nxt.io[`IOD_CMP_CS]      = st_nxt.io[`IOD_CMP_CS] | ({8{evt.cmp}} & `IOD_F_CMP);
	end

	// clk_en low freezes everything, events included
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_r <= '0;
		end
		else if (clk_en)
		begin
			st_r <= st_nxt;
		end
	end

	assign io_regs   = st_r.io;
	assign pin_level = st_r.lvl;

endmodule : iod_decoder
`default_nettype wire

// file: rtl/iod_map.svh
// iod_map.svh: offsets, field masks and reset values of the lower I/O register space.
// assumes: included by the decoder; definitions only.
`ifndef IOD_MAP_SVH
`define IOD_MAP_SVH

// address translation
`define IOD_DS_OFFSET     8'h20
`define IOD_EXT_BASE      8'h60
`define IOD_BIT_TOP       6'h1f

// io addresses
`define IOD_PORT_B_OUTPUT_LVL     6'h03
`define IOD_PORT_B_OUTPUT_DIR     6'h04
`define IOD_PORT_B_OUTPUT_OUT     6'h05
`define IOD_PORT_C_OUTPUT_LVL     6'h06
`define IOD_PORT_C_OUTPUT_DIR     6'h07
`define IOD_PORT_C_OUTPUT_OUT     6'h08
`define IOD_PORT_D_OUTPUT_LVL     6'h09
`define IOD_PORT_D_OUTPUT_DIR     6'h0a
`define IOD_PORT_D_OUTPUT_OUT     6'h0b
`define IOD_PORT_A_OUTPUT_LVL     6'h0c
`define IOD_PORT_A_OUTPUT_DIR     6'h0d
`define IOD_PORT_A_OUTPUT_OUT     6'h0e
`define IOD_PULL_CTL      6'h12
`define IOD_TMR0_FLAGS    6'h15
`define IOD_TMR1_FLAGS    6'h16
`define IOD_PCGRP_FLAGS   6'h1b
`define IOD_EXTLN_FLAGS   6'h1c
`define IOD_EXTLN_MASK    6'h1d
`define IOD_SCRATCH0      6'h1e
`define IOD_NVM_CTL       6'h1f
`define IOD_NVM_DATA      6'h20
`define IOD_NVM_ADDR_LO   6'h21
`define IOD_PRESC_CTL     6'h23
`define IOD_TMR0_CTL      6'h25
`define IOD_TMR0_COUNT    6'h26
`define IOD_TMR0_CMP_A    6'h27
`define IOD_TMR0_CMP_B    6'h28
`define IOD_SCRATCH1      6'h2a
`define IOD_SCRATCH2      6'h2b
`define IOD_SER_CTL       6'h2c
`define IOD_SER_STAT      6'h2d
`define IOD_SER_DATA      6'h2e
`define IOD_CMP_CS        6'h30
`define IOD_DBG_DATA      6'h31
`define IOD_SLEEP_CTL     6'h33

// writable field masks
`define IOD_M_FULL        8'hff
`define IOD_M_PORT_A_OUTPUT       8'h0f
`define IOD_M_EXTLN       8'h03
`define IOD_M_NVM_CTL     8'h3f
`define IOD_M_PRESC       8'h81
`define IOD_M_TMR0_CTL    8'h0f
`define IOD_M_SER_STAT    8'h01
`define IOD_M_CMP_RW      8'hcf
`define IOD_M_SLEEP       8'h07

// write-one-to-clear flag masks
`define IOD_F_TMR0        8'h07
`define IOD_F_TMR1        8'h27
`define IOD_F_PCGRP       8'h0f
`define IOD_F_EXTLN       8'h03
`define IOD_F_CMP         8'h10

// read-only status bit positions
`define IOD_CMP_LVL_BIT   5
`define IOD_SER_FLAG_LSB  6

`define IOD_RST_BYTE      8'h00

`endif

// file: rtl/iod_pkg.sv
// iod_pkg: types shared by the I/O space decoder and its surroundings.
// assumes: iod_map.svh supplies the numbers.
`default_nettype none
package iod_pkg;

	typedef enum logic [7:0] {
		iod_op_io_in                  = 8'h01,
		iod_op_io_out                 = 8'h02,
		iod_op_data_space_load        = 8'h04,
		iod_op_data_space_store       = 8'h08,
		iod_op_set_io_bit_instruction = 8'h10,
		iod_op_clr_io_bit_instruction = 8'h20,
		iod_op_skip_if_io_bit_set     = 8'h40,
		iod_op_skip_if_io_bit_clear   = 8'h80
	} iod_op_t;

	typedef struct packed {
		logic        valid;
		iod_op_t     op;
		logic [7:0]  addr;
		logic [2:0]  bit_sel;
		logic [7:0]  wdata;
	} iod_req_t;

	typedef struct packed {
		logic [7:0]  rdata;
		logic        skip;
		logic        hit;
		logic        ext_sel;
		logic        rd_stb;
		logic        wr_stb;
		logic [5:0]  io_addr;
	} iod_rsp_t;

	typedef struct packed {
		logic [7:0]  tmr0;
		logic [7:0]  tmr1;
		logic [7:0]  pcgrp;
		logic [7:0]  extln;
		logic        cmp;
	} iod_evt_t;

	typedef struct packed {
		logic [1:0]  ser_flags;
		logic        cmp_level;
	} iod_stat_t;

	typedef struct packed {
		logic [63:0][7:0] io;
		logic [3:0][7:0]  s1;
		logic [3:0][7:0]  s2;
		logic [3:0][7:0]  s3;
		logic [3:0][7:0]  lvl;
	} iod_state_t;

endpackage : iod_pkg
`default_nettype wire

// file: verification/io_register_space_decoder_bench.sv
// io_register_space_decoder_bench: core model drives the decoder, answers are
// compared with a behavioural register model; assumes the checker is bound.
`timescale 1ns/10ps
`default_nettype none
module io_register_space_decoder_bench
	import iod_pkg::*;
;
	logic            ref_clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic            clk_en = 1'b1;
	iod_req_t        req;
	iod_rsp_t        rsp;
	iod_rsp_t        r;
	iod_evt_t        evt = '0;
	iod_stat_t       stat = '0;
	logic [3:0][7:0] pins_in = '0;
	logic [3:0][7:0] pin_lvl;
	int              n_errors = 0;
	int              compares = 0;
	int              seed = 32'h59b3c17e;
	logic [7:0]      m [64];
	logic [7:0]      ra [6] = '{8'h05, 8'h1e, 8'h2a, 8'h2b, 8'h2e, 8'h20};
	initial forever #2 ref_clk = ~ref_clk;
	iod_core_model u_iod_core_model (.ref_clk(ref_clk), .rsp(rsp), .req(req));
	iod_decoder u_iod_decoder (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.req(req), .rsp(rsp), .evt(evt), .stat(stat), .pins_in(pins_in), .io_regs(),
		.pin_level(pin_lvl));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic acc(input logic [7:0] o, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] d);
		u_iod_core_model.issue(o, a, b, d, r);
	endtask : acc
	initial
	begin
		stat = 3'($random(seed));
		pins_in = 32'($random(seed));
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		foreach (ra[k])
		begin
			m[ra[k]] = 8'($random(seed));
			acc(8'h02, ra[k], 3'h0, m[ra[k]]);
			chk(r.wr_stb, 8'h01);
			acc(8'h04, ra[k] + 8'h20, 3'h0, 8'h00);
			chk(r.rdata, m[ra[k]]);
		end
		acc(8'h02, 8'h0e, 3'h0, 8'hff);
		acc(8'h01, 8'h0e, 3'h0, 8'h00);
		chk(r.rdata, 8'h0f);
		acc(8'h01, 8'h01, 3'h0, 8'h00);
		chk(r.rdata, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			acc(i[0] ? 8'h20 : 8'h10, 8'h05, i[2:0], 8'h00);
			m[5][i] = !i[0];
			acc(8'h40, 8'h05, i[2:0], 8'h00);
			chk(r.skip, {7'h00, m[5][i]});
			acc(8'h80, 8'h05, i[2:0], 8'h00);
			chk(r.skip, {7'h00, !m[5][i]});
		end
		acc(8'h01, 8'h05, 3'h0, 8'h00);
		chk(r.rdata, m[5]);
		acc(8'h10, 8'h2a, 3'h7, 8'h00);
		chk(r.hit, 8'h00);
		acc(8'h01, 8'h2a, 3'h0, 8'h00);
		chk(r.rdata, m[8'h2a]);
		u_iod_core_model.idle();
		evt.tmr0 = 8'h07;
		@(negedge ref_clk);
		evt.tmr0 = 8'h00;
		acc(8'h02, 8'h15, 3'h0, 8'h01);
		acc(8'h01, 8'h15, 3'h0, 8'h00);
		chk(r.rdata, 8'h06);
		acc(8'h10, 8'h15, 3'h1, 8'h00);
		acc(8'h20, 8'h15, 3'h2, 8'h00);
		acc(8'h02, 8'h15, 3'h0, 8'h00);
		acc(8'h01, 8'h15, 3'h0, 8'h00);
		chk(r.rdata, 8'h04);
		// every flag source pulses once; reserved flag bits must stay zero
		u_iod_core_model.idle();
		evt = '{8'hff, 8'hff, 8'hff, 8'hff, 1'b1};
		@(negedge ref_clk);
		evt = '0;
		acc(8'h01, 8'h16, 3'h0, 8'h00);
		chk(r.rdata, 8'h27);
		acc(8'h01, 8'h1b, 3'h0, 8'h00);
		chk(r.rdata, 8'h0f);
		acc(8'h01, 8'h1c, 3'h0, 8'h00);
		chk(r.rdata, 8'h03);
		acc(8'h01, 8'h30, 3'h0, 8'h00);
		chk(r.rdata, {2'b00, stat.cmp_level, 1'b1, 4'h0});
		// an event in the clearing cycle keeps its flag
		acc(8'h02, 8'h16, 3'h0, 8'h27);
		evt.tmr1 = 8'h01;
		acc(8'h01, 8'h16, 3'h0, 8'h00);
		evt.tmr1 = 8'h00;
		chk(r.rdata, 8'h01);
		acc(8'h01, 8'h2d, 3'h0, 8'h00);
		chk(r.rdata, {stat.ser_flags, 6'h00});
		acc(8'h01, 8'h03, 3'h0, 8'h00);
		chk(r.rdata, pins_in[1]);
		acc(8'h04, 8'h2c, 3'h0, 8'h00);
		chk(r.rdata, pins_in[0] & 8'h0f);
		chk(pin_lvl[2], pins_in[2]);
		chk(pin_lvl[3], pins_in[3]);
		m[30] = 8'h3c;
		acc(8'h08, 8'h3e, 3'h0, m[30]);
		chk(r.wr_stb, 8'h01);
		acc(8'h01, 8'h1e, 3'h0, 8'h00);
		chk(r.rdata, m[30]);
		acc(8'h04, 8'h60, 3'h0, 8'h00);
		chk({r.ext_sel, r.hit}, 8'h02);
		acc(8'h01, 8'h45, 3'h0, 8'h00);
		chk(r.hit, 8'h00);
		clk_en = 1'b0;
		acc(8'h02, 8'h1e, 3'h0, ~m[30]);
		u_iod_core_model.idle();
		clk_en = 1'b1;
		acc(8'h01, 8'h1e, 3'h0, 8'h00);
		chk(r.rdata, m[30]);
		end_sim();
	end
	initial
	begin
		#20000;
		n_errors++;
		end_sim();
	end
endmodule : io_register_space_decoder_bench
`default_nettype wire

// file: verification/iod_core_model.sv
// iod_core_model: core side, one request per call, held until replaced.
// assumes: one calling process; same clock as the decoder.
`timescale 1ns/10ps
`default_nettype none
module iod_core_model
	import iod_pkg::*;
(
	input  wire logic     ref_clk,
	input  wire iod_rsp_t rsp,
	output var iod_req_t  req
);
	initial req = '0;
	// callers may write ones to reserved bits and may access reserved addresses
	task automatic issue(input logic [7:0] op, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] w, output iod_rsp_t r);
		@(negedge ref_clk);
		req <= '{1'b1, iod_op_t'(op), a, b, w};
		#1 r = rsp;
	endtask : issue
	// released request lines show inverted leftovers, not stale values
	task automatic idle;
		@(negedge ref_clk);
		req <= '{1'b0, iod_op_t'(~req.op), ~req.addr, ~req.bit_sel, ~req.wdata};
	endtask : idle
endmodule : iod_core_model
`default_nettype wire

// file: verification/iod_decoder_properties.sv
// iod_chk: port-level properties of the I/O space decoder.
// assumes: bound into iod_decoder; one clock, async active-high reset.
`timescale 1ns/10ps
`default_nettype none
module iod_chk
	import iod_pkg::*;
(
	input wire logic             ref_clk,
	input wire logic             sys_rst,
	input wire logic             clk_en,
	input wire iod_req_t         req,
	input wire iod_rsp_t         rsp,
	input wire iod_evt_t         evt,
	input wire logic [63:0][7:0] io_regs
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire       q = req.valid;
	wire       v = q && clk_en;
	wire [7:0] o = req.op;
	wire [7:0] a = req.addr;
	// no event in flight, so the flag byte moves only by the access
	wire       f = v && a == 8'h15 && evt.tmr0 == 8'h00;
	property p_bit_range; q && |o[7:4] && a > 8'h1f |-> !rsp.hit && !rsp.skip; endproperty
	a_bit_range: assert property (p_bit_range) else $error("bit op hit above range");
	property p_skip;
		q && |o[7:6] && a == 8'h05 |-> rsp.skip == (io_regs[5][req.bit_sel] ^ o[7]);
	endproperty
	a_skip: assert property (p_skip) else $error("skip result wrong");
	property p_w1c; f && o[1] |=> io_regs[21] == ($past(io_regs[21]) & ~$past(req.wdata));
	endproperty
	a_w1c: assert property (p_w1c) else $error("flag write wrong");
	property p_bit_flag;
		f && |o[5:4] |=> io_regs[21] ==
			($past(io_regs[21]) & ~({7'h00, $past(o[4])} << $past(req.bit_sel)));
	endproperty
	a_bit_flag: assert property (p_bit_flag) else $error("bit op hit other flags");
	property p_io_map;
		q && o[0] |-> rsp.hit == (a < 8'h40) && (a > 8'h3f || rsp.io_addr == a[5:0]);
	endproperty
	a_io_map: assert property (p_io_map) else $error("io decode wrong");
	property p_ds_map;
		q && |o[3:2] && a < 8'h60 |-> rsp.hit == (a > 8'h1f) && (a < 8'h20 || rsp.io_addr ==
			a[5:0] - 6'h20);
	endproperty
	a_ds_map: assert property (p_ds_map) else $error("data space decode wrong");
	property p_ext; q && a > 8'h5f |-> !rsp.hit && rsp.ext_sel == |o[3:2]; endproperty
	a_ext: assert property (p_ext) else $error("extended decode wrong");
	property p_wr; v && o[1] && a == 8'h1e |=> io_regs[30] == $past(req.wdata); endproperty
	a_wr: assert property (p_wr) else $error("write not one cycle");
	c_flag: cover property (f && o[1]);
	c_ext: cover property (rsp.ext_sel);
	c_skip: cover property (rsp.skip);
endmodule : iod_chk
bind iod_decoder iod_chk u_iod_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
	.req(req), .rsp(rsp), .evt(evt), .io_regs(io_regs));
`default_nettype wire
